/* File: design/msc_en_edge.sv */
`timescale 1ns/1ns
module msc_en_edge (
	// clock and reset
	input logic clk,
	input logic rstn,
	// enable input
	input logic enable_in,
	// edge events
	msc_evt_if.edg evt
);
	logic en_prev;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			en_prev <= 1'b0;
		else
			en_prev <= enable_in;
	end

	// only edges count, never a static level
	assign evt.en_rise = enable_in & ~en_prev;
	assign evt.en_fall = ~enable_in & en_prev;
endmodule : msc_en_edge

/* File: design/msc_evt_if.sv */
`timescale 1ns/1ns
interface msc_evt_if;
	logic ms_tick;
	logic en_rise;
	logic en_fall;
	modport div (output ms_tick);
	modport edg (output en_rise, output en_fall);
	modport core (input ms_tick, input en_rise, input en_fall);
endinterface : msc_evt_if

/* File: design/msc_muting.sv */
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
module msc_muting #(
	parameter int MS_CYCLES = msc_pkg::MS_CYCLES
) (
	// clock and reset
	input logic clk,
	input logic rstn,
	// apb slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sensors, guard, enable
	input logic sensor_a,
	input logic sensor_b,
	input logic sensor_c,
	input logic sensor_d,
	input logic guard_in,
	input logic enable_in,
	// outputs
	output logic safe_out,
	output logic muting_active,
	output logic blind_active
);
	msc_evt_if evt();
	msc_pkg::msc_state_t state;
	msc_pkg::msc_state_t next_state;
	msc_pkg::msc_layout_t cfg_layout;
	msc_pkg::msc_dir_t cfg_dir;
	logic cfg_close_sensor;
	logic cfg_en_opt;
	logic cfg_en_only;
	logic cfg_blind;
	logic cfg_min;
	logic cfg_no_tmo;
	logic [19:0] sens_ms;
	logic [19:0] tmo_ms;
	logic [19:0] blind_ms;
	logic [19:0] lend_ms;
	logic [19:0] cnt;
	logic [19:0] l_cnt;
	logic armed;
	logic en_ok;
	logic clean;
	logic dir_dn;
	logic next_dn;
	logic guard_low_seen;
	logic third_seen;
	logic l_released;
	logic four_sensor;
	logic prelim;
	logic up_cand;
	logic dn_cand;
	logic up_allow;
	logic dn_allow;
	logic pair_both;
	logic pair_any;
	logic lead_clear;
	logic third_occ;
	logic normal_close;
	logic abort;
	logic start;
	logic fail;
	logic wr;
	logic rd_setup;
	logic mapped;

	msc_tick_div #(.CYC(MS_CYCLES)) u_div (
		.clk(clk),
		.rstn(rstn),
		.evt(evt)
	);

	msc_en_edge u_edge (
		.clk(clk),
		.rstn(rstn),
		.enable_in(enable_in),
		.evt(evt)
	);

	////////////////////////////////////////////////////////////////
	// apb register access
	assign mapped = (paddr == msc_pkg::ADDR_CTRL) || (paddr == msc_pkg::ADDR_SENS) ||
		(paddr == msc_pkg::ADDR_TMO) || (paddr == msc_pkg::ADDR_BLIND) ||
		(paddr == msc_pkg::ADDR_LEND) || (paddr == msc_pkg::ADDR_STAT);
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;
	assign wr = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cfg_layout <= msc_pkg::msc_layout_t'(msc_pkg::RST_CTRL[1:0]);
			cfg_dir <= msc_pkg::msc_dir_t'(msc_pkg::RST_CTRL[3:2]);
			cfg_close_sensor <= msc_pkg::RST_CTRL[msc_pkg::CTL_CLOSE_SENSOR];
			cfg_en_opt <= msc_pkg::RST_CTRL[msc_pkg::CTL_EN_OPT];
			cfg_en_only <= msc_pkg::RST_CTRL[msc_pkg::CTL_EN_ONLY];
			cfg_blind <= msc_pkg::RST_CTRL[msc_pkg::CTL_BLIND];
			cfg_min <= msc_pkg::RST_CTRL[msc_pkg::CTL_MIN_TIME];
			cfg_no_tmo <= msc_pkg::RST_CTRL[msc_pkg::CTL_NO_TMO];
			sens_ms <= msc_pkg::RST_SENS_MS;
			tmo_ms <= msc_pkg::RST_TMO_MS;
			blind_ms <= msc_pkg::RST_BLIND_MS;
			lend_ms <= msc_pkg::RST_LEND_MS;
		end
		else if (wr)
		begin
			case (paddr)
				msc_pkg::ADDR_CTRL:
				begin
					cfg_layout <= msc_pkg::msc_layout_t'(pwdata[msc_pkg::CTL_LAYOUT +: 2]);
					cfg_dir <= msc_pkg::msc_dir_t'(pwdata[msc_pkg::CTL_DIR +: 2]);
					cfg_close_sensor <= pwdata[msc_pkg::CTL_CLOSE_SENSOR];
					cfg_en_opt <= pwdata[msc_pkg::CTL_EN_OPT];
					cfg_en_only <= pwdata[msc_pkg::CTL_EN_ONLY];
					cfg_blind <= pwdata[msc_pkg::CTL_BLIND];
					cfg_min <= pwdata[msc_pkg::CTL_MIN_TIME];
					cfg_no_tmo <= pwdata[msc_pkg::CTL_NO_TMO];
				end
				msc_pkg::ADDR_SENS: sens_ms <= pwdata[19:0];
				msc_pkg::ADDR_TMO: tmo_ms <= pwdata[19:0];
				msc_pkg::ADDR_BLIND: blind_ms <= pwdata[19:0];
				msc_pkg::ADDR_LEND: lend_ms <= pwdata[19:0];
				default: ;
			endcase
		end
	end

	// read data is latched in the setup cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
		begin
			case (paddr)
				msc_pkg::ADDR_CTRL: prdata <= {22'h00_0000, cfg_no_tmo, cfg_min, cfg_blind, cfg_en_only,
					cfg_en_opt, cfg_close_sensor, cfg_dir, cfg_layout};
				msc_pkg::ADDR_SENS: prdata <= {12'h000, sens_ms};
				msc_pkg::ADDR_TMO: prdata <= {12'h000, tmo_ms};
				msc_pkg::ADDR_BLIND: prdata <= {12'h000, blind_ms};
				msc_pkg::ADDR_LEND: prdata <= {12'h000, lend_ms};
				msc_pkg::ADDR_STAT: prdata <= {17'h0_0000, armed, clean, dir_dn, blind_active, muting_active,
					safe_out, state, guard_in, sensor_d, sensor_c, sensor_b, sensor_a};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// enable arming
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			armed <= 1'b0;
		else if (evt.en_rise)
			armed <= 1'b1;
		else if (start || (evt.en_fall && !cfg_en_only))
			armed <= 1'b0;
	end

	assign en_ok = !cfg_en_opt || armed;

	////////////////////////////////////////////////////////////////
	// sensor decode
	assign four_sensor = (cfg_layout == msc_pkg::MSC_CONC) || (cfg_layout == msc_pkg::MSC_SEQ);
	assign prelim = four_sensor ? (guard_in && !sensor_a && !sensor_b && !sensor_c && !sensor_d)
		: (guard_in && !sensor_a && !sensor_b);
	assign up_allow = (cfg_dir == msc_pkg::MSC_UP) || (cfg_dir == msc_pkg::MSC_BIDIRECTIONAL) || !four_sensor;
	assign dn_allow = ((cfg_dir == msc_pkg::MSC_DOWN) || (cfg_dir == msc_pkg::MSC_BIDIRECTIONAL)) && four_sensor;

	always_comb
	begin
		up_cand = 1'b0;
		dn_cand = 1'b0;
		case (cfg_layout)
			msc_pkg::MSC_CONC:
			begin
				up_cand = (sensor_a || sensor_b) && !sensor_c && !sensor_d;
				dn_cand = (sensor_c || sensor_d) && !sensor_a && !sensor_b;
			end
			msc_pkg::MSC_SEQ:
			begin
				up_cand = sensor_a && !sensor_c && !sensor_d;
				dn_cand = sensor_d && !sensor_a && !sensor_b;
			end
			default: up_cand = sensor_a || sensor_b;
		endcase
	end

	assign pair_both = dir_dn ? (sensor_c && sensor_d) : (sensor_a && sensor_b);
	assign pair_any = dir_dn ? (sensor_c || sensor_d) : (sensor_a || sensor_b);
	assign lead_clear = dir_dn ? (!sensor_c && !sensor_d) : (!sensor_a && !sensor_b);
	assign third_occ = dir_dn ? sensor_b : sensor_c;

	////////////////////////////////////////////////////////////////
	// cycle control
	assign start = (state == msc_pkg::MSC_IDLE) && clean && en_ok &&
		((up_cand && up_allow) || (dn_cand && dn_allow));
	// a sensor in the wrong order or, in the sequential layout, a b-first sequence drops the cycle
	assign fail = (state == msc_pkg::MSC_IDLE) && clean && en_ok && !prelim && !start &&
		(sensor_a || sensor_b || (four_sensor && (sensor_c || sensor_d)));
	assign abort = (cfg_en_opt && !cfg_en_only && evt.en_fall) ||
		(!cfg_no_tmo && (cnt >= tmo_ms)) ||
		((cfg_layout == msc_pkg::MSC_LSHAPE) && l_released && (l_cnt >= lend_ms));
	assign normal_close = (four_sensor && cfg_close_sensor) ?
		(third_seen && !third_occ) :
		(guard_low_seen && guard_in && lead_clear);

	always_comb
	begin
		next_state = state;
		next_dn = dir_dn;
		case (state)
			msc_pkg::MSC_IDLE:
			begin
				if (start)
				begin
					next_state = msc_pkg::MSC_PAIR;
					next_dn = !(up_cand && up_allow);
				end
			end
			msc_pkg::MSC_PAIR:
			begin
				if (cfg_en_opt && !cfg_en_only && evt.en_fall)
					next_state = msc_pkg::MSC_IDLE;
				else if (pair_both)
				begin
					if ((cnt <= sens_ms) && (!cfg_min || (cnt >= msc_pkg::MIN_SENS_MS)))
						next_state = msc_pkg::MSC_MUTE;
					else
						next_state = msc_pkg::MSC_IDLE;
				end
				else if (!pair_any || (cnt > sens_ms))
					next_state = msc_pkg::MSC_IDLE;
			end
			msc_pkg::MSC_MUTE:
			begin
				if (abort)
					next_state = msc_pkg::MSC_IDLE;
				else if (normal_close)
				begin
					if (cfg_blind && (!four_sensor || !cfg_close_sensor))
						next_state = msc_pkg::MSC_BLIND;
					else
						next_state = msc_pkg::MSC_IDLE;
				end
			end
			msc_pkg::MSC_BLIND:
			begin
				if (cnt >= blind_ms)
					next_state = msc_pkg::MSC_IDLE;
			end
			default: next_state = msc_pkg::MSC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= msc_pkg::MSC_IDLE;
			dir_dn <= 1'b0;
		end
		else
		begin
			state <= next_state;
			dir_dn <= next_dn;
		end
	end

	// preliminary condition must be seen again before each cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			clean <= 1'b0;
		else if (state != msc_pkg::MSC_IDLE || next_state != msc_pkg::MSC_IDLE || fail)
			clean <= 1'b0;
		else if (prelim)
			clean <= 1'b1;
		else if (!guard_in)
			clean <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// millisecond counters
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cnt <= 20'h0_0000;
		else if (next_state != state)
			cnt <= 20'h0_0000;
		else if (evt.ms_tick && (cnt != 20'hF_FFFF))
			cnt <= cnt + 20'h0_0001;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			l_released <= 1'b0;
			l_cnt <= 20'h0_0000;
		end
		else if (state != msc_pkg::MSC_MUTE)
		begin
			l_released <= 1'b0;
			l_cnt <= 20'h0_0000;
		end
		else if (!sensor_a)
		begin
			l_released <= 1'b1;
			if (l_released && evt.ms_tick && (l_cnt != 20'hF_FFFF))
				l_cnt <= l_cnt + 20'h0_0001;
		end
	end

	// progress of the load through the opening
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			guard_low_seen <= 1'b0;
			third_seen <= 1'b0;
		end
		else if (state != msc_pkg::MSC_MUTE)
		begin
			guard_low_seen <= 1'b0;
			third_seen <= 1'b0;
		end
		else
		begin
			if (!guard_in)
				guard_low_seen <= 1'b1;
			if (third_occ)
				third_seen <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			muting_active <= 1'b0;
			blind_active <= 1'b0;
			safe_out <= 1'b0;
		end
		else
		begin
			muting_active <= (next_state == msc_pkg::MSC_MUTE);
			blind_active <= (next_state == msc_pkg::MSC_BLIND);
			safe_out <= guard_in || (next_state == msc_pkg::MSC_MUTE) ||
				(next_state == msc_pkg::MSC_BLIND);
		end
	end
endmodule : msc_muting

/* File: design/msc_pkg.sv */
package msc_pkg;
	// sensor layouts
	typedef enum logic [1:0] {
		MSC_CONC = 2'h0,
		MSC_LSHAPE = 2'h1,
		MSC_SEQ = 2'h2,
		MSC_TSHAPE = 2'h3
	} msc_layout_t;
	// travel direction
	typedef enum logic [1:0] {
		MSC_UP = 2'h0,
		MSC_DOWN = 2'h1,
		MSC_BIDIRECTIONAL = 2'h2
	} msc_dir_t;
	// cycle states
	typedef enum logic [3:0] {
		MSC_IDLE = 4'h1,
		MSC_PAIR = 4'h2,
		MSC_MUTE = 4'h4,
		MSC_BLIND = 4'h8
	} msc_state_t;
	////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_HZ = 32'h0131_2D00;
	localparam int MS_PER_S = 32'h0000_03E8;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam logic [19:0] MIN_SENS_MS = 20'h0_0096;
	////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SENS = 8'h04;
	localparam logic [7:0] ADDR_TMO = 8'h08;
	localparam logic [7:0] ADDR_BLIND = 8'h0C;
	localparam logic [7:0] ADDR_LEND = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	// control field positions
	localparam int CTL_LAYOUT = 0;
	localparam int CTL_DIR = 2;
	localparam int CTL_CLOSE_SENSOR = 4;
	localparam int CTL_EN_OPT = 5;
	localparam int CTL_EN_ONLY = 6;
	localparam int CTL_BLIND = 7;
	localparam int CTL_MIN_TIME = 8;
	localparam int CTL_NO_TMO = 9;
	// values after reset, times in ms
	localparam logic [9:0] RST_CTRL = 10'h008;
	localparam logic [19:0] RST_SENS_MS = 20'h0_1388;
	localparam logic [19:0] RST_TMO_MS = 20'h0_2710;
	localparam logic [19:0] RST_BLIND_MS = 20'h0_00FA;
	localparam logic [19:0] RST_LEND_MS = 20'h0_09C4;
endpackage : msc_pkg

/* File: design/msc_tick_div.sv */
`timescale 1ns/1ns
module msc_tick_div #(
	parameter int CYC = msc_pkg::MS_CYCLES
) (
	// clock and reset
	input logic clk,
	input logic rstn,
	// millisecond enable
	msc_evt_if.div evt
);
	logic [19:0] div_cnt;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_cnt <= 20'h0_0000;
			evt.ms_tick <= 1'b0;
		end
		else if (div_cnt == 20'(CYC - 1))
		begin
			div_cnt <= 20'h0_0000;
			evt.ms_tick <= 1'b1;
		end
		else
		begin
			div_cnt <= div_cnt + 20'h0_0001;
			evt.ms_tick <= 1'b0;
		end
	end
endmodule : msc_tick_div

/* File: test/msc_field_model.sv */
`timescale 1ns/1ns
module msc_field_model (
	// clock
	input wire logic clk,
	// requested scene: guard, d, c, b, a
	input wire logic [4:0] scene,
	// sensor and curtain lines
	output logic sensor_a,
	output logic sensor_b,
	output logic sensor_c,
	output logic sensor_d,
	output logic guard_in
);
	// lines change only after a clock edge
	always_ff @(posedge clk)
		{guard_in, sensor_d, sensor_c, sensor_b, sensor_a} <= scene;
endmodule : msc_field_model

/* File: test/msc_muting_bench.sv */
`timescale 1ns/1ns
module msc_muting_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, err, sensor_a, sensor_b, sensor_c, sensor_d, guard_in;
	logic safe_out, muting_active, blind_active;
	logic enable_in = 1'b0;
	logic [4:0] scene = 5'h10;
	int bad_count = 0;
	int checks_done = 0;
	always #25 clk = ~clk;
	msc_field_model u_field (.clk(clk), .scene(scene), .sensor_a(sensor_a), .sensor_b(sensor_b),
		.sensor_c(sensor_c), .sensor_d(sensor_d), .guard_in(guard_in));
	msc_muting #(.MS_CYCLES(20)) u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sensor_a(sensor_a), .sensor_b(sensor_b), .sensor_c(sensor_c),
		.sensor_d(sensor_d), .guard_in(guard_in), .enable_in(enable_in), .safe_out(safe_out),
		.muting_active(muting_active), .blind_active(blind_active));
	////////////////////////////////////////////////////////////////
	task test_done;
		if (bad_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task put(input logic [4:0] v, input int n);
		scene <= v;
		wt(n);
	endtask : put
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only pready or the watchdog ends a wait
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		wt(1);
	endtask : apb
	// clean scene, first sensors, then the full pair
	task pair(input logic [4:0] first, input logic [4:0] both, input int gap);
		put(5'h10, 4);
		put(first, gap);
		put(both, 4);
	endtask : pair
	////////////////////////////////////////////////////////////////
	task t_regs;
		logic [31:0] rv [5] = '{32'h0000_0008, 32'h0000_1388, 32'h0000_2710, 32'h0000_00FA, 32'h0000_09C4};
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, 8'(i * 4), 32'h0000_0000);
			chk(rd, rv[i], "reset value");
		end
		apb(1'b1, 8'h18, 32'hFFFF_FFFF);
		chk(err, 1'b1, "unmapped error");
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "unmapped read");
		// short times in ms: sensor 10, timeout 50, blind 5, end 5
		apb(1'b1, 8'h04, 32'h0000_000A);
		apb(1'b1, 8'h08, 32'h0000_0032);
		apb(1'b1, 8'h0C, 32'h0000_0005);
		apb(1'b1, 8'h10, 32'h0000_0005);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(rd, 32'h0000_000A, "readback");
	endtask : t_regs
	task t_conc;
		apb(1'b1, 8'h00, 32'h0000_0088);
		pair(5'h11, 5'h13, 40);
		chk(muting_active, 1'b1, "concurrent start");
		put(5'h03, 4);
		chk(safe_out, 1'b1, "guard ignored");
		put(5'h0F, 4);
		put(5'h0C, 4);
		put(5'h1C, 4);
		chk(muting_active, 1'b0, "curtain close");
		chk(blind_active, 1'b1, "blind begins");
		put(5'h0C, 4);
		chk(safe_out, 1'b1, "blind holds");
		wt(200);
		chk(blind_active, 1'b0, "blind ends");
		chk(safe_out, 1'b0, "guard passes");
	endtask : t_conc
	task t_slow;
		pair(5'h11, 5'h13, 300);
		chk(muting_active, 1'b0, "slow pair");
	endtask : t_slow
	task t_min;
		apb(1'b1, 8'h00, 32'h0000_0108);
		pair(5'h11, 5'h13, 20);
		chk(muting_active, 1'b0, "fast pair");
	endtask : t_min
	task t_dir;
		apb(1'b1, 8'h00, 32'h0000_0000);
		pair(5'h14, 5'h1C, 40);
		chk(muting_active, 1'b0, "wrong direction");
		put(5'h0C, 4);
		chk(safe_out, 1'b0, "guard passes");
	endtask : t_dir
	task t_tmo;
		apb(1'b1, 8'h00, 32'h0000_0008);
		pair(5'h11, 5'h13, 40);
		chk(muting_active, 1'b1, "start");
		wt(900);
		chk(muting_active, 1'b1, "before timeout");
		wt(200);
		chk(muting_active, 1'b0, "timeout");
	endtask : t_tmo
	task t_en;
		apb(1'b1, 8'h00, 32'h0000_0028);
		pair(5'h11, 5'h13, 40);
		chk(muting_active, 1'b0, "static low");
		enable_in <= 1'b1;
		pair(5'h11, 5'h13, 40);
		chk(muting_active, 1'b1, "armed by edge");
		enable_in <= 1'b0;
		wt(4);
		chk(muting_active, 1'b0, "enable fall");
	endtask : t_en
	// enable-only: a fall does not cancel, curtain closes the cycle
	task t_eonly;
		apb(1'b1, 8'h00, 32'h0000_0068);
		enable_in <= 1'b1;
		pair(5'h11, 5'h13, 40);
		chk(muting_active, 1'b1, "enable-only start");
		enable_in <= 1'b0;
		wt(4);
		chk(muting_active, 1'b1, "fall ignored");
		put(5'h03, 4);
		put(5'h10, 4);
		chk(muting_active, 1'b0, "curtain close");
	endtask : t_eonly
	task t_seq;
		apb(1'b1, 8'h00, 32'h0000_001A);
		pair(5'h18, 5'h1C, 40);
		chk(muting_active, 1'b1, "sequential down");
		put(5'h0E, 4);
		put(5'h0F, 4);
		put(5'h07, 4);
		put(5'h03, 4);
		put(5'h13, 4);
		chk(muting_active, 1'b1, "third still held");
		put(5'h11, 4);
		chk(muting_active, 1'b0, "sensor close");
	endtask : t_seq
	////////////////////////////////////////////////////////////////
	initial
	begin
		#(50 * 20000);
		bad_count++;
		test_done();
	end
	initial
	begin
		wt(20);
		rstn <= 1'b1;
		wt(2);
		t_regs();
		t_conc();
		t_slow();
		t_min();
		t_dir();
		t_tmo();
		t_en();
		t_eonly();
		t_seq();
		test_done();
	end
endmodule : msc_muting_bench

/* File: test/msc_muting_sva.sv */
`timescale 1ns/1ns
module msc_muting_sva #(
	parameter int MS_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sensor_a,
	input wire logic sensor_b,
	input wire logic sensor_c,
	input wire logic sensor_d,
	input wire logic guard_in,
	input wire logic safe_out,
	input wire logic muting_active,
	input wire logic blind_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence mute_run;
		muting_active ##1 muting_active;
	endsequence
	sequence blind_run;
		blind_active ##1 blind_active;
	endsequence
	pready_zero_a: assert property (pready == (psel && penable))
		else $error("pready not in access phase");
	err_access_a: assert property (pslverr |-> pready)
		else $error("pslverr outside access");
	start_pair_a: assert property (!((sensor_a && sensor_b) || (sensor_c && sensor_d)) |=> !$rose(muting_active))
		else $error("muting began without a full pair");
	mute_hold_a: assert property (mute_run |-> safe_out)
		else $error("output low while muting");
	idle_pass_a: assert property ($past(rstn) && !muting_active && !blind_active && !$past(muting_active)
		&& !$past(blind_active) |-> safe_out == $past(guard_in))
		else $error("guard not passed through");
	state_excl_a: assert property (!(muting_active && blind_active))
		else $error("muting and blind together");
	blind_entry_a: assert property ($rose(blind_active) |-> $past(muting_active))
		else $error("blind without a closing cycle");
	blind_min_a: assert property ($rose(blind_active) |-> blind_active [*8])
		else $error("blind time too short");
	blind_safe_a: assert property (blind_run |-> safe_out)
		else $error("output low during blind");
endmodule : msc_muting_sva
bind msc_muting msc_muting_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.clk(clk), .rstn(rstn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .sensor_a(sensor_a), .sensor_b(sensor_b),
	.sensor_c(sensor_c), .sensor_d(sensor_d), .guard_in(guard_in), .safe_out(safe_out),
	.muting_active(muting_active), .blind_active(blind_active));
